// [pkg/dtmf_defs.vh]
`ifndef DTMF_DEFS_VH
`define DTMF_DEFS_VH

// ==========================================
// clock and synthesis
`define SYS_CLK_HZ 64'h0000_0000_0098_9680
`define STEPS_PER_PERIOD 64'h0000_0000_0000_0010
`define ACC_W 24
`define STEP_W 4
`define DAC_IDLE 4'h8

// ==========================================
// tone frequencies in hz
`define ROW1_HZ 64'h0000_0000_0000_02b9
`define ROW2_HZ 64'h0000_0000_0000_0302
`define ROW3_HZ 64'h0000_0000_0000_0354
`define ROW4_HZ 64'h0000_0000_0000_03ad
`define COL1_HZ 64'h0000_0000_0000_04b9
`define COL2_HZ 64'h0000_0000_0000_0538
`define COL3_HZ 64'h0000_0000_0000_05c5
`define COL4_HZ 64'h0000_0000_0000_0661

// ==========================================
// serial port
`define CODE_BITS 3'h4
`define READ_CYCLES 3'h6
`define CODE_IDLE 4'hf

// ==========================================
// register map
`define ADDR_W 4
`define DATA_W 8
`define REG_STATUS 4'h0
`define REG_MASK 4'h1
`define REG_STATE 4'h2
`define EV_KEY 0
`define EV_READ 1
`define EV_LOAD 2
`define EV_W 3

`endif

// [src/dtmf_tone_synth.v]
`timescale 1ns/100ps
`include "dtmf_defs.vh"

module dtmf_tone_synth (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // tone selection
  input wire row_enable,
  input wire column_enable,
  input wire [1:0] row_index,
  input wire [1:0] column_index,
  // staircase amplitudes to the converters
  output reg [3:0] row_level,
  output reg [3:0] column_level
);

  // ==========================================
  // fractional divider increments
  // accumulator carry gives a non-integer ratio, error far below 0.16 pct
  function [`ACC_W-1:0] tone_increment;
    input [1:0] idx;
    input is_column;
    reg [63:0] hz;
    reg [63:0] prod;
    begin
      case ({is_column, idx})
        3'h0: hz = `ROW1_HZ;
        3'h1: hz = `ROW2_HZ;
        3'h2: hz = `ROW3_HZ;
        3'h3: hz = `ROW4_HZ;
        3'h4: hz = `COL1_HZ;
        3'h5: hz = `COL2_HZ;
        3'h6: hz = `COL3_HZ;
        default: hz = `COL4_HZ;
      endcase
      prod = ((hz * `STEPS_PER_PERIOD) << `ACC_W) / `SYS_CLK_HZ;
      tone_increment = prod[`ACC_W-1:0];
    end
  endfunction

  // ==========================================
  // sixteen-step sine staircase
  function [3:0] sine_step;
    input [`STEP_W-1:0] step;
    begin
      case (step)
        4'h0: sine_step = 4'h8;
        4'h1: sine_step = 4'hb;
        4'h2: sine_step = 4'hd;
        4'h3: sine_step = 4'he;
        4'h4: sine_step = 4'hf;
        4'h5: sine_step = 4'he;
        4'h6: sine_step = 4'hd;
        4'h7: sine_step = 4'hb;
        4'h8: sine_step = 4'h8;
        4'h9: sine_step = 4'h5;
        4'ha: sine_step = 4'h3;
        4'hb: sine_step = 4'h2;
        4'hc: sine_step = 4'h1;
        4'hd: sine_step = 4'h2;
        4'he: sine_step = 4'h3;
        default: sine_step = 4'h5;
      endcase
    end
  endfunction

  reg [`ACC_W-1:0] row_acc_reg;
  reg [`ACC_W-1:0] col_acc_reg;
  reg [`STEP_W-1:0] row_step_reg;
  reg [`STEP_W-1:0] col_step_reg;
  wire [`ACC_W:0] row_sum;
  wire [`ACC_W:0] col_sum;

  assign row_sum = {1'b0, row_acc_reg} + {1'b0, tone_increment(row_index, 1'b0)}; // (R3)
  assign col_sum = {1'b0, col_acc_reg} + {1'b0, tone_increment(column_index, 1'b1)}; // (R3)

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      row_acc_reg <= {`ACC_W{1'b0}};
      col_acc_reg <= {`ACC_W{1'b0}};
      row_step_reg <= {`STEP_W{1'b0}};
      col_step_reg <= {`STEP_W{1'b0}};
      row_level <= `DAC_IDLE;
      column_level <= `DAC_IDLE;
    end
    else
    begin
      if (row_enable)
      begin
        row_acc_reg <= row_sum[`ACC_W-1:0];
        row_step_reg <= row_step_reg + {{(`STEP_W-1){1'b0}}, row_sum[`ACC_W]}; // (R4)
        row_level <= sine_step(row_step_reg); // (R4)
      end
      else
      begin
        row_acc_reg <= {`ACC_W{1'b0}};
        row_step_reg <= {`STEP_W{1'b0}};
        row_level <= `DAC_IDLE;
      end
      if (column_enable)
      begin
        col_acc_reg <= col_sum[`ACC_W-1:0];
        col_step_reg <= col_step_reg + {{(`STEP_W-1){1'b0}}, col_sum[`ACC_W]}; // (R4)
        column_level <= sine_step(col_step_reg); // (R4)
      end
      else
      begin
        col_acc_reg <= {`ACC_W{1'b0}};
        col_step_reg <= {`STEP_W{1'b0}};
        column_level <= `DAC_IDLE;
      end
    end
  end

endmodule // dtmf_tone_synth

// [src/dtmf_dialer_serial_port.v]
// Notes on behaviour
// (R1) row-column contact starts both tone generators
// (R2) shared row or column gives single tone
// (R3) fractional dividers synthesize eight tones accurately
// (R4) sixteen-step sine staircase per period
// (R5) four-bit key code selects the tones
// (R6) fixed key code table, bits three to zero
// (R7) one data pin, direction input sets way
// (R8) direction low: keypad code to tones, serial out
// (R9) msb first, one bit per falling edge
// (R10) six clocks read and reload the register
// (R11) direction high: four clocks shift code in
// (R12) keypad ignored while direction high; the code still drives single_key_flag and the key status event from the keypad
// (R13) inhibit suppresses tones, keypad stays active
// (R14) host holds inhibit until code loaded
// (R15) single-key flag only for exactly one key
// (R16) host waits 20 us after flag rises
// (R17) tone-active flag follows generator enable
// (R18) data pin high after power-up, direction low
// (R19) host orders inhibit, direction, bits, release
`timescale 1ns/100ps
`include "dtmf_defs.vh"

module dtmf_dialer_serial_port (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // keypad
  input wire [3:0] row_inputs,
  input wire [3:0] column_inputs,
  // host port
  input wire transfer_direction,
  input wire shift_clock_n,
  input wire tone_inhibit,
  input wire serial_data_in,
  output wire serial_data_out,
  output wire serial_data_oe,
  output reg single_key_flag,
  output reg tone_active_mute_flag,
  // tone converters
  output wire [3:0] row_level,
  output wire [3:0] column_level,
  // register port
  input wire [`ADDR_W-1:0] reg_addr,
  input wire [`DATA_W-1:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  output reg [`DATA_W-1:0] reg_rdata,
  output wire irq
);

  // ==========================================
  // helpers
  function is_one_hot;
    input [3:0] v;
    begin
      is_one_hot = (v != 4'h0) && ((v & (v - 4'h1)) == 4'h0);
    end
  endfunction

  function [1:0] line_index;
    input [3:0] v;
    begin
      casez (v)
        4'b???1: line_index = 2'h0;
        4'b??10: line_index = 2'h1;
        4'b?100: line_index = 2'h2;
        default: line_index = 2'h3;
      endcase
    end
  endfunction

  // same mapping both ways: index 0..3 <-> code field 11,01,10,00
  function [1:0] code_field;
    input [1:0] v;
    begin
      code_field = ~{v[0], v[1]}; // (R6)
    end
  endfunction

  // ==========================================
  // input synchronisers
  reg [3:0] row_s1_reg;
  reg [3:0] row_s2_reg;
  reg [3:0] col_s1_reg;
  reg [3:0] col_s2_reg;
  reg dir_s1_reg;
  reg dir_s2_reg;
  reg sclk_s1_reg;
  reg sclk_s2_reg;
  reg inh_s1_reg;
  reg inh_s2_reg;
  reg din_s1_reg;
  reg din_s2_reg;

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      row_s1_reg <= 4'hf;
      row_s2_reg <= 4'hf;
      col_s1_reg <= 4'h0;
      col_s2_reg <= 4'h0;
      dir_s1_reg <= 1'b0;
      dir_s2_reg <= 1'b0;
      sclk_s1_reg <= 1'b1;
      sclk_s2_reg <= 1'b1;
      inh_s1_reg <= 1'b1;
      inh_s2_reg <= 1'b1;
      din_s1_reg <= 1'b1;
      din_s2_reg <= 1'b1;
    end
    else
    begin
      row_s1_reg <= row_inputs;
      row_s2_reg <= row_s1_reg;
      col_s1_reg <= column_inputs;
      col_s2_reg <= col_s1_reg;
      dir_s1_reg <= transfer_direction;
      dir_s2_reg <= dir_s1_reg;
      sclk_s1_reg <= shift_clock_n;
      sclk_s2_reg <= sclk_s1_reg;
      inh_s1_reg <= tone_inhibit;
      inh_s2_reg <= inh_s1_reg;
      din_s1_reg <= serial_data_in;
      din_s2_reg <= din_s1_reg;
    end
  end

  // ==========================================
  // keypad decode
  // rows pull up and go low on contact, columns go high
  wire [3:0] row_active;
  wire [3:0] col_active;
  wire row_single;
  wire col_single;
  wire any_contact;
  wire key_single;
  wire [3:0] keypad_code;

  assign row_active = ~row_s2_reg;
  assign col_active = col_s2_reg;
  assign row_single = is_one_hot(row_active);
  assign col_single = is_one_hot(col_active);
  assign any_contact = (row_active != 4'h0) && (col_active != 4'h0); // (R1)
  assign key_single = row_single & col_single; // (R15)
  assign keypad_code = {code_field(line_index(col_active)),
                        code_field(line_index(row_active))}; // (R5) (R6)

  // ==========================================
  // serial shift register
  reg [3:0] shift_reg;
  reg [2:0] edge_cnt_reg;
  reg code_valid_reg;
  reg sclk_prev_reg;
  reg dir_prev_reg;
  reg ev_read_reg;
  reg ev_load_reg;
  wire clk_fall;
  wire dir_change;

  assign clk_fall = sclk_prev_reg & ~sclk_s2_reg; // (R9)
  assign dir_change = dir_s2_reg ^ dir_prev_reg;

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      shift_reg <= `CODE_IDLE; // (R18)
      edge_cnt_reg <= 3'h0;
      code_valid_reg <= 1'b0;
      sclk_prev_reg <= 1'b1;
      dir_prev_reg <= 1'b0;
      ev_read_reg <= 1'b0;
      ev_load_reg <= 1'b0;
    end
    else
    begin
      sclk_prev_reg <= sclk_s2_reg;
      dir_prev_reg <= dir_s2_reg;
      ev_read_reg <= 1'b0;
      ev_load_reg <= 1'b0;
      if (dir_change)
      begin
        edge_cnt_reg <= 3'h0;
        code_valid_reg <= 1'b0;
      end
      else if (dir_s2_reg)
      begin
        // shift in from the host, keypad not looked at
        if (clk_fall)
        begin
          shift_reg <= {shift_reg[2:0], din_s2_reg}; // (R9) (R11)
          if (edge_cnt_reg == `CODE_BITS - 3'h1)
          begin
            edge_cnt_reg <= 3'h0;
            code_valid_reg <= 1'b1; // (R11)
            ev_load_reg <= 1'b1;
          end
          else
          begin
            edge_cnt_reg <= edge_cnt_reg + 3'h1;
            code_valid_reg <= 1'b0;
          end
        end
      end
      else if (clk_fall)
      begin
        // ones fill behind so the pin rests high
        if (edge_cnt_reg < `CODE_BITS)
          shift_reg <= {shift_reg[2:0], 1'b1}; // (R8) (R9)
        if (edge_cnt_reg == `READ_CYCLES - 3'h1)
        begin
          edge_cnt_reg <= 3'h0; // (R10)
          ev_read_reg <= 1'b1;
        end
        else
          edge_cnt_reg <= edge_cnt_reg + 3'h1;
      end
      else if ((edge_cnt_reg == 3'h0) && key_single)
        shift_reg <= keypad_code; // (R10)
    end
  end

  assign serial_data_out = shift_reg[3]; // (R7)
  assign serial_data_oe = ~dir_s2_reg; // (R7)

  // ==========================================
  // tone selection multiplexer
  reg row_en_reg;
  reg col_en_reg;
  reg [1:0] row_idx_reg;
  reg [1:0] col_idx_reg;
  reg row_en_next;
  reg col_en_next;
  reg [1:0] row_idx_next;
  reg [1:0] col_idx_next;

  always @*
  begin
    if (dir_s2_reg)
    begin
      // automatic: code from the shift register only
      row_en_next = code_valid_reg; // (R12)
      col_en_next = code_valid_reg;
      row_idx_next = code_field(shift_reg[1:0]); // (R5)
      col_idx_next = code_field(shift_reg[3:2]);
    end
    else
    begin
      // two keys on one line leave only that line's tone
      row_en_next = any_contact & row_single; // (R1) (R2)
      col_en_next = any_contact & col_single; // (R2)
      row_idx_next = code_field(keypad_code[1:0]); // (R8)
      col_idx_next = code_field(keypad_code[3:2]);
    end
    if (inh_s2_reg)
    begin
      row_en_next = 1'b0; // (R13)
      col_en_next = 1'b0; // (R13)
    end
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      row_en_reg <= 1'b0;
      col_en_reg <= 1'b0;
      row_idx_reg <= 2'h0;
      col_idx_reg <= 2'h0;
      single_key_flag <= 1'b0;
      tone_active_mute_flag <= 1'b0;
    end
    else
    begin
      row_en_reg <= row_en_next;
      col_en_reg <= col_en_next;
      row_idx_reg <= row_idx_next;
      col_idx_reg <= col_idx_next;
      single_key_flag <= key_single; // (R15)
      tone_active_mute_flag <= row_en_next | col_en_next; // (R17)
    end
  end

  dtmf_tone_synth synth (
    .sys_clk(sys_clk),
    .reset(reset),
    .row_enable(row_en_reg),
    .column_enable(col_en_reg),
    .row_index(row_idx_reg),
    .column_index(col_idx_reg),
    .row_level(row_level),
    .column_level(column_level)
  );

  // ==========================================
  // status, mask and register port
  reg [`EV_W-1:0] status_reg;
  reg [`EV_W-1:0] mask_reg;
  reg [`EV_W-1:0] status_next;
  wire [`EV_W-1:0] events;
  wire key_rise;

  assign key_rise = key_single & ~single_key_flag;
  assign events = {ev_load_reg, ev_read_reg, key_rise};

  // set wins over a same-cycle clear
  always @*
  begin
    status_next = status_reg;
    if (reg_write && (reg_addr == `REG_STATUS))
      status_next = status_next & ~reg_wdata[`EV_W-1:0];
    status_next = status_next | events;
  end

  always @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      status_reg <= {`EV_W{1'b0}};
      mask_reg <= {`EV_W{1'b0}};
      reg_rdata <= {`DATA_W{1'b0}};
    end
    else
    begin
      status_reg <= status_next;
      if (reg_write && (reg_addr == `REG_MASK))
        mask_reg <= reg_wdata[`EV_W-1:0];
      reg_rdata <= {`DATA_W{1'b0}};
      if (reg_read)
      begin
        case (reg_addr)
          `REG_STATUS: reg_rdata <= {{(`DATA_W-`EV_W){1'b0}}, status_reg};
          `REG_MASK: reg_rdata <= {{(`DATA_W-`EV_W){1'b0}}, mask_reg};
          `REG_STATE: reg_rdata <= {1'b0, dir_s2_reg, inh_s2_reg,
                                    code_valid_reg, shift_reg};
          default: reg_rdata <= {`DATA_W{1'b0}};
        endcase
      end
    end
  end

  assign irq = |(status_reg & mask_reg);

endmodule // dtmf_dialer_serial_port

// [bench/dtmf_dialer_serial_port_assertions.sv]
`timescale 1ns/100ps
module dtmf_dialer_serial_port_checker (
  // clock and reset
  input wire sys_clk,
  input wire reset,
  // keypad and host port
  input wire [3:0] row_inputs,
  input wire [3:0] column_inputs,
  input wire transfer_direction,
  input wire shift_clock_n,
  input wire tone_inhibit,
  input wire serial_data_out,
  input wire serial_data_oe,
  input wire single_key_flag,
  input wire tone_active_mute_flag,
  input wire [3:0] row_level,
  input wire [3:0] column_level,
  // register port
  input wire [3:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire reg_write,
  input wire reg_read,
  input wire [7:0] reg_rdata,
  input wire irq
);
  wire key_one;
  wire idle_pad;
  assign key_one = $onehot(~row_inputs) && $onehot(column_inputs);
  assign idle_pad = !transfer_direction && row_inputs == 4'hf;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // ==========================================
  // pin and flag relations
  property p_oe;
    (transfer_direction == $past(transfer_direction)) [*4] |-> serial_data_oe == !transfer_direction;
  endproperty
  a_oe: assert property (p_oe) else $error("pin enable wrong");
  property p_boot;
    $past(reset) |-> serial_data_out && serial_data_oe;
  endproperty
  a_boot: assert property (p_boot) else $error("data pin not high");
  property p_single;
    (!transfer_direction && key_one == $past(key_one)) [*5] |-> single_key_flag == key_one;
  endproperty
  a_single: assert property (p_single) else $error("single key flag wrong");
  property p_inh;
    tone_inhibit [*8] |-> !tone_active_mute_flag && row_level == 4'h8 && column_level == 4'h8;
  endproperty
  a_inh: assert property (p_inh) else $error("tone while inhibited");
  property p_nokey;
    (idle_pad && column_inputs == 4'h0) [*8] |-> !tone_active_mute_flag && row_level == 4'h8;
  endproperty
  a_nokey: assert property (p_nokey) else $error("tone without key");
  property p_hold;
    (idle_pad && shift_clock_n) [*6] |-> $stable(serial_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("data moved without fall");
  // ==========================================
  // register port
  property p_rdata;
    !$past(reg_read) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside slot");
  property p_mask;
    (reg_write && reg_addr == 4'h1 && reg_wdata == 8'h00) ##1 !reg_write |-> ##1 !irq;
  endproperty
  a_mask: assert property (p_mask) else $error("masked irq high");
endmodule // dtmf_dialer_serial_port_checker

bind dtmf_dialer_serial_port dtmf_dialer_serial_port_checker dtmf_dialer_serial_port_checker_i (
  .sys_clk(sys_clk), .reset(reset), .row_inputs(row_inputs), .column_inputs(column_inputs),
  .transfer_direction(transfer_direction), .shift_clock_n(shift_clock_n),
  .tone_inhibit(tone_inhibit), .serial_data_out(serial_data_out),
  .serial_data_oe(serial_data_oe), .single_key_flag(single_key_flag),
  .tone_active_mute_flag(tone_active_mute_flag), .row_level(row_level),
  .column_level(column_level), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .irq(irq));

// [bench/host_port_model.sv]
`timescale 1ns/100ps
module host_port_model (
  // clock
  input wire sys_clk,
  // lines from the dialer
  input wire serial_data_out,
  input wire single_key_flag,
  // lines to the dialer
  output reg shift_clock_n,
  output reg transfer_direction,
  output reg tone_inhibit,
  output wire host_line
);
  reg host_drive;
  reg host_data;
  // released line floats up to its pull-up, never keeps the last bit
  assign host_line = host_drive ? host_data : 1'b1;
  initial
  begin
    shift_clock_n = 1'b1;
    transfer_direction = 1'b0;
    tone_inhibit = 1'b0;
    host_drive = 1'b0;
    host_data = 1'b0;
  end
  task ticks(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  // half of an 800 ns link period
  task half(input lvl);
  begin
    shift_clock_n <= lvl;
    ticks(4);
  end
  endtask
  task set_inhibit(input lvl);
  begin
    ticks(1);
    tone_inhibit <= lvl;
  end
  endtask
  task read_code(output [3:0] c);
    integer i;
  begin
    i = 0;
    ticks(1);
    while (single_key_flag !== 1'b1 && i < 100)
    begin
      ticks(1);
      i = i + 1;
    end
    ticks(200);
    for (i = 0; i < 6; i = i + 1)
    begin
      if (i < 4)
        c[3 - i] = serial_data_out;
      half(1'b0);
      half(1'b1);
    end
  end
  endtask
  task load_code(input [3:0] c);
    integer i;
  begin
    set_inhibit(1'b1);
    ticks(200);
    transfer_direction <= 1'b1;
    ticks(200);
    host_drive <= 1'b1;
    for (i = 3; i >= 0; i = i - 1)
    begin
      host_data <= c[i];
      half(1'b1);
      half(1'b0);
    end
    half(1'b1);
    host_drive <= 1'b0;
    ticks(100);
  end
  endtask
endmodule // host_port_model

// [bench/testbench.sv]
`timescale 1ns/100ps
module testbench;
  reg sys_clk;
  reg reset;
  reg [3:0] row_inputs;
  reg [3:0] column_inputs;
  reg [3:0] reg_addr;
  reg [7:0] reg_wdata;
  reg reg_write;
  reg reg_read;
  wire transfer_direction;
  wire shift_clock_n;
  wire tone_inhibit;
  wire host_line;
  wire serial_data_in;
  wire serial_data_out;
  wire serial_data_oe;
  wire single_key_flag;
  wire tone_active_mute_flag;
  wire [3:0] row_level;
  wire [3:0] column_level;
  wire [7:0] reg_rdata;
  wire irq;
  integer num_errors;
  integer cmp_count;
  // key codes row by row, one nibble each
  localparam [63:0] code_tab = 64'hf7b3_d591_e6a2_c480;
  assign serial_data_in = serial_data_oe ? serial_data_out : host_line;
  dtmf_dialer_serial_port dtmf_dialer_serial_port_i (
    .sys_clk(sys_clk), .reset(reset), .row_inputs(row_inputs), .column_inputs(column_inputs),
    .transfer_direction(transfer_direction), .shift_clock_n(shift_clock_n),
    .tone_inhibit(tone_inhibit), .serial_data_in(serial_data_in),
    .serial_data_out(serial_data_out), .serial_data_oe(serial_data_oe),
    .single_key_flag(single_key_flag), .tone_active_mute_flag(tone_active_mute_flag),
    .row_level(row_level), .column_level(column_level), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .irq(irq));
  host_port_model host_port_model_i (
    .sys_clk(sys_clk), .serial_data_out(serial_data_out), .single_key_flag(single_key_flag),
    .shift_clock_n(shift_clock_n), .transfer_direction(transfer_direction),
    .tone_inhibit(tone_inhibit), .host_line(host_line));
  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  task ticks(input integer n);
    repeat (n) @(posedge sys_clk);
  endtask
  task chk(input [11:0] got, input [11:0] exp);
  begin
    cmp_count = cmp_count + 1;
    if (got !== exp)
    begin
      num_errors = num_errors + 1;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task give_verdict;
  begin
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  // ==========================================
  // register port and keypad drivers
  task reg_wr(input [3:0] a, input [7:0] d);
  begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  end
  endtask
  task rd_chk(input [3:0] a, input [7:0] m, input [7:0] exp);
  begin
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1;
    chk(reg_rdata & m, exp);
  end
  endtask
  task keys(input [3:0] r, input [3:0] c);
  begin
    @(posedge sys_clk);
    row_inputs <= r;
    column_inputs <= c;
  end
  endtask
  // ==========================================
  // scenarios
  task t_keys;
    integer k;
    reg [3:0] c;
  begin
    for (k = 0; k < 16; k = k + 1)
    begin
      keys(~(4'h1 << (k / 4)), 4'h1 << (k % 4));
      host_port_model_i.read_code(c);
      chk(c, code_tab[63 - 4 * k -: 4]);
      chk({single_key_flag, tone_active_mute_flag}, 12'h3);
      host_port_model_i.read_code(c);
      chk(c, code_tab[63 - 4 * k -: 4]);
      keys(4'hf, 4'h0);
      ticks(20);
      chk({single_key_flag, tone_active_mute_flag}, 12'h0);
    end
  end
  endtask
  task t_inhibit;
  begin
    host_port_model_i.set_inhibit(1'b1);
    keys(4'hd, 4'h4);
    ticks(20);
    chk({single_key_flag, tone_active_mute_flag, row_level, column_level}, 12'h288);
    host_port_model_i.set_inhibit(1'b0);
    keys(4'hf, 4'h0);
    ticks(20);
  end
  endtask
  task t_two;
    integer n;
    integer t_up;
    integer t_mid;
    reg cv;
  begin
    keys(4'he, 4'h3);
    t_up = 0;
    t_mid = 0;
    cv = 1'b0;
    for (n = 0; n < 8000; n = n + 1)
    begin
      ticks(1);
      if (row_level !== 4'h8 && t_up == 0)
        t_up = n;
      if (row_level === 4'h8 && t_up != 0 && t_mid == 0)
        t_mid = n;
      if (column_level !== 4'h8)
        cv = 1'b1;
    end
    chk({t_up != 0, cv, single_key_flag, tone_active_mute_flag}, 12'h9);
    // step 1 to step 8 is 7/16 of a 697 hz period: 6277 cycles, 0.16 pct margin
    chk((t_mid - t_up) > 6266 && (t_mid - t_up) < 6288, 12'h1);
    keys(4'hf, 4'h0);
    ticks(20);
  end
  endtask
  task t_regs;
  begin
    reg_wr(4'h1, 8'hff);
    rd_chk(4'h1, 8'hff, 8'h07);
    ticks(3);
    chk(irq, 12'h1);
    reg_wr(4'h1, 8'h00);
    ticks(3);
    chk(irq, 12'h0);
    rd_chk(4'h0, 8'hff, 8'h03);
    reg_wr(4'h1, 8'h07);
    reg_wr(4'h0, 8'h07);
    ticks(3);
    chk(irq, 12'h0);
    rd_chk(4'h0, 8'hff, 8'h00);
    reg_wr(4'h5, 8'hff);
    rd_chk(4'h5, 8'hff, 8'h00);
  end
  endtask
  task t_load;
  begin
    host_port_model_i.load_code(4'h5);
    keys(4'he, 4'h1);
    ticks(20);
    chk({serial_data_oe, tone_active_mute_flag}, 12'h0);
    rd_chk(4'h2, 8'hff, 8'h75);
    host_port_model_i.set_inhibit(1'b0);
    ticks(20);
    chk({tone_active_mute_flag, irq}, 12'h3);
    rd_chk(4'h2, 8'hff, 8'h55);
    rd_chk(4'h0, 8'h04, 8'h04);
  end
  endtask
  initial
  begin
    num_errors = 0;
    cmp_count = 0;
    reset = 1'b1;
    row_inputs = 4'hf;
    column_inputs = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk({serial_data_oe, serial_data_out, single_key_flag, tone_active_mute_flag}, 12'hc);
    t_keys;
    t_inhibit;
    t_two;
    t_regs;
    t_load;
    give_verdict;
  end
  // run needs about 17000 cycles
  initial
  begin
    #3000000;
    num_errors = num_errors + 1;
    give_verdict;
  end
endmodule // testbench
